// ---- design/paip_pkg.sv ----
// Package of constants and carrier types for the parallel audio input port
package paip_pkg;
  localparam int PAIP_DATA_W = 24;
  localparam int PAIP_FIFO_DEPTH = 16;
  localparam logic [23:0] PAIP_WORD_RST = 24'h00_0000;
  localparam logic PAIP_PIN_IDLE = 1'b1;

  // One sample pair, channel A and channel B
  typedef struct packed {
    logic [PAIP_DATA_W-1:0] chan_a;
    logic [PAIP_DATA_W-1:0] chan_b;
  } paip_pair_s;

  // Port pins as seen by the device
  typedef struct packed {
    logic [PAIP_DATA_W-1:0] data;
    logic chan_sel;
    logic strobe;
  } paip_pins_s;

  typedef enum logic [1:0] {
    PAIP_IDLE,
    PAIP_WAIT_READ
  } paip_irq_e;
endpackage

// ---- design/paip_fifo.sv ----
// Parameterised valid/ready FIFO for sample pairs
`timescale 1ns/1ps
module paip_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Honest full and empty from the occupancy count
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_q];

  // Storage array
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // paip_fifo

// ---- design/paip_port.sv ----
// Parallel audio input port: strobe capture, channel latches, pair FIFO, interrupt
`timescale 1ns/1ps
module paip_port #(
  parameter int DATA_W = paip_pkg::PAIP_DATA_W,
  parameter int FIFO_DEPTH = paip_pkg::PAIP_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [DATA_W-1:0] pin_data,
  input wire logic pin_chan_sel,
  input wire logic pin_strobe,
  input wire logic pin_chan_sel_conn,
  input wire logic pin_strobe_conn,
  output logic irq,
  input wire logic pair_read,
  output logic [DATA_W-1:0] pair_chan_a,
  output logic [DATA_W-1:0] pair_chan_b,
  output logic pair_valid,
  output logic overrun
);
  import paip_pkg::*;

  logic sel_in;
  logic stb_in;
  logic [2:0] stb_sync_q;
  logic [1:0] sel_sync_q;
  logic [DATA_W-1:0] data_sync_q [2];
  logic stb_rise;
  logic [DATA_W-1:0] lat_a_q;
  logic [DATA_W-1:0] lat_b_q;
  logic b_capture;
  logic fifo_in_ready;
  logic [2*DATA_W-1:0] fifo_out;
  logic fifo_out_valid;
  logic out_pop;
  paip_irq_e irq_q;
  logic [DATA_W-1:0] out_a_q;
  logic [DATA_W-1:0] out_b_q;
  logic overrun_q;

  // Open pins are pulled high
  assign sel_in = pin_chan_sel_conn ? pin_chan_sel : PAIP_PIN_IDLE;
  assign stb_in = pin_strobe_conn ? pin_strobe : PAIP_PIN_IDLE;

  // Two-stage synchronisers, third strobe stage for edge detect
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stb_sync_q <= {3{PAIP_PIN_IDLE}};
      sel_sync_q <= {2{PAIP_PIN_IDLE}};
    end else begin
      stb_sync_q <= {stb_sync_q[1:0], stb_in};
      sel_sync_q <= {sel_sync_q[0], sel_in};
    end
  end

  // Data delayed to match strobe path so it is stable when captured
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      data_sync_q[0] <= '0;
      data_sync_q[1] <= '0;
    end else begin
      data_sync_q[0] <= pin_data;
      data_sync_q[1] <= data_sync_q[0];
    end
  end

  // Rising strobe seen between the second and third stages
  assign stb_rise = stb_sync_q[1] && !stb_sync_q[2];
  assign b_capture = stb_rise && sel_sync_q[1];

  // Channel latches selected by channel select
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lat_a_q <= PAIP_WORD_RST;
      lat_b_q <= PAIP_WORD_RST;
    end else if (stb_rise) begin
      if (sel_sync_q[1]) begin
        lat_b_q <= data_sync_q[1];
      end else begin
        lat_a_q <= data_sync_q[1];
      end
    end
  end

  // Pair FIFO absorbs processor service delay
  paip_fifo #(
    .WIDTH(2*DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .nrst(nrst),
    .in_data({lat_a_q, data_sync_q[1]}),
    .in_valid(b_capture),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(out_pop)
  );

  // Load output pair when idle or on read of the current one
  assign out_pop = fifo_out_valid && (irq_q == PAIP_IDLE || pair_read);

  // Interrupt pending while an unread pair is presented
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_q <= PAIP_IDLE;
    end else begin
      case (irq_q)
        PAIP_IDLE: begin
          if (out_pop) begin
            irq_q <= PAIP_WAIT_READ;
          end
        end
        PAIP_WAIT_READ: begin
          if (pair_read && !out_pop) begin
            irq_q <= PAIP_IDLE;
          end
        end
        default: irq_q <= PAIP_IDLE;
      endcase
    end
  end

  // Output data registers hold the pair for the processor
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      out_a_q <= PAIP_WORD_RST;
      out_b_q <= PAIP_WORD_RST;
    end else if (out_pop) begin
      out_a_q <= fifo_out[2*DATA_W-1:DATA_W];
      out_b_q <= fifo_out[DATA_W-1:0];
    end
  end

  // Sticky overrun when a pair arrives with the FIFO full; set wins over clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      overrun_q <= 1'b0;
    end else if (b_capture && !fifo_in_ready) begin
      overrun_q <= 1'b1;
    end else if (pair_read) begin
      overrun_q <= 1'b0;
    end
  end

  assign irq = (irq_q == PAIP_WAIT_READ);
  assign pair_valid = irq;
  assign pair_chan_a = out_a_q;
  assign pair_chan_b = out_b_q;
  assign overrun = overrun_q;
endmodule // paip_port

// ---- sim/paip_port_assertions.sv ----
// Checker of port timing for the parallel audio input port
`timescale 1ns/1ps
module paip_port_chk (
  input wire logic clock,
  input wire logic nrst,
  input wire logic pin_chan_sel,
  input wire logic pin_strobe,
  input wire logic pin_chan_sel_conn,
  input wire logic pin_strobe_conn,
  input wire logic irq,
  input wire logic pair_read,
  input wire logic [23:0] pair_chan_a,
  input wire logic [23:0] pair_chan_b,
  input wire logic pair_valid,
  input wire logic overrun
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Interrupt, pair data and overrun relations
  valid_irq_a: assert property (pair_valid == irq) else $error("valid differs");
  irq_clear_a: assert property ($fell(irq) |-> $past(pair_read)) else $error("irq fell");
  irq_stands_a: assert property (irq && !pair_read |=> irq) else $error("irq lost");
  pair_hold_a: assert property (irq && !pair_read |=>
    $stable({pair_chan_a, pair_chan_b})) else $error("pair moved");
  ovr_clear_a: assert property ($fell(overrun) |-> $past(pair_read)) else $error("ovr fell");
  ovr_full_a: assert property ($rose(overrun) |-> irq) else $error("ovr idle");
  stb_idle_a: assert property ((pin_strobe || !pin_strobe_conn) [*6] |=>
    !$rose(irq)) else $error("irq no edge");
  sel_low_a: assert property ((pin_chan_sel_conn && !pin_chan_sel) [*6] |=>
    !$rose(irq)) else $error("irq on A");
  // Main scenarios
  c_irq: cover property ($rose(irq));
  c_ovr: cover property ($rose(overrun));
  c_rd: cover property (irq && pair_read);
endmodule // paip_port_chk
bind paip_port paip_port_chk u_chk (.clock, .nrst, .pin_chan_sel, .pin_strobe,
  .pin_chan_sel_conn, .pin_strobe_conn, .irq, .pair_read, .pair_chan_a, .pair_chan_b,
  .pair_valid, .overrun);

// ---- sim/paip_src.sv ----
// Model of the external parallel sample source
`timescale 1ns/1ps
module paip_src (
  input wire logic clock,
  output logic [23:0] pin_data,
  output logic pin_chan_sel,
  output logic pin_strobe
);
  // Idle with strobe high
  initial begin
    pin_data = 24'h00_0000;
    pin_chan_sel = 1'b1;
    pin_strobe = 1'b1;
  end
  // One word on the shared lines, strobe low two cycles then rising
  task automatic send(input logic s, input logic [23:0] w);
    @(posedge clock);
    pin_chan_sel <= s; // Steady while strobe low
    pin_data <= w;
    pin_strobe <= 1'b0;
    repeat (2) @(posedge clock);
    pin_strobe <= 1'b1;
    repeat (3) @(posedge clock);
    pin_data <= ~w; // Hold time over
  endtask
endmodule // paip_src

// ---- sim/paip_port_tb_top.sv ----
// Self-checking bench for the parallel audio input port
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("Error %0t mismatch", $time); end end
module paip_port_tb_top;
  logic clock = 0, nrst = 0, pin_chan_sel_conn = 1, pin_strobe_conn = 1, pair_read = 0;
  logic [23:0] pin_data, pair_chan_a, pair_chan_b;
  logic pin_chan_sel, pin_strobe, irq, pair_valid, overrun;
  int err_count = 0, compares = 0;
  paip_src u_paip_src (.clock, .pin_data, .pin_chan_sel, .pin_strobe);
  paip_port u_paip_port (.clock, .nrst, .pin_data, .pin_chan_sel, .pin_strobe,
    .pin_chan_sel_conn, .pin_strobe_conn, .irq, .pair_read, .pair_chan_a, .pair_chan_b,
    .pair_valid, .overrun);
  always #5 clock = ~clock;
  task automatic finish_test();
    if (err_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Bounded wait for the interrupt
  task automatic wirq();
    repeat (20) begin
      #1;
      if (irq === 1'b1) break;
      @(posedge clock);
    end
  endtask
  // One read pulse from the processor
  task automatic rdp();
    @(posedge clock);
    pair_read <= 1'b1;
    @(posedge clock);
    pair_read <= 1'b0;
    #1;
  endtask
  task automatic t_pair();
    u_paip_src.send(1'b0, 24'h80_0001);
    u_paip_src.send(1'b1, 24'h7f_ff00);
    wirq();
    `CHK(pair_chan_a, 24'h80_0001)
    `CHK(pair_chan_b, 24'h7f_ff00)
    `CHK(irq, 1'b1)
    `CHK(pair_valid, 1'b1)
    rdp();
    `CHK(irq, 1'b0)
  endtask
  task automatic t_mono();
    @(posedge clock);
    pin_chan_sel_conn <= 1'b0; // Select floats high, mono source
    u_paip_src.send(1'b0, 24'h12_3400); // Narrow word, low lines zero
    wirq();
    `CHK(pair_chan_a, 24'h80_0001)
    `CHK(pair_chan_b, 24'h12_3400)
    rdp();
    @(posedge clock);
    pin_chan_sel_conn <= 1'b1;
  endtask
  task automatic t_unconn();
    @(posedge clock);
    pin_strobe_conn <= 1'b0;
    u_paip_src.send(1'b1, 24'h55_5555);
    repeat (6) @(posedge clock);
    #1;
    `CHK(irq, 1'b0)
    @(posedge clock);
    pin_strobe_conn <= 1'b1;
  endtask
  task automatic t_over();
    int n;
    for (int i = 0; i < 20; i++) u_paip_src.send(1'b1, 24'(i));
    wirq();
    `CHK(overrun, 1'b1)
    for (n = 0; n < 30 && irq === 1'b1; n++) begin
      `CHK(pair_chan_b, 24'(n))
      rdp();
    end
    `CHK(n, paip_pkg::PAIP_FIFO_DEPTH + 1)
    rdp();
    `CHK(overrun, 1'b0)
  endtask
  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    t_pair();
    t_mono();
    t_unconn();
    t_over();
    finish_test();
  end
  // Watchdog
  initial begin
    #200000;
    err_count++;
    finish_test();
  end
endmodule // paip_port_tb_top
